// file: verification/pmt_tb.sv
// self-checking bench for the three-unit period match timer
// assumes pmt_top with a strobe register port, one 200 MHz clock
`timescale 1ns/10ps
`default_nettype none
module tb;
	import pmt_pkg::*;
	logic ref_clk, resetn, sleep;
	pmt_bus_s bus;
	logic [7:0] rdata_q;
	logic [PMT_UNITS-1:0] match_q;
	logic irq_q;
	int failures, compares, cyc;

	pmt_top DUT (.ref_clk(ref_clk), .resetn(resetn), .sleep(sleep), .bus(bus),
		.rdata_q(rdata_q), .match_q(match_q), .irq_q(irq_q));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) cyc <= cyc + 1;

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [4:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1;
		chk(what, {8'h00, rdata_q}, {8'h00, exp});
	endtask
	// bounded wait for one unscaled pulse of a unit, returns its cycle
	task automatic wait_match(input int u, output int t);
		for (int i = 0; i < 1000; i++) begin
			@(posedge ref_clk);
			#1;
			if (match_q[u] === 1'b1) break;
		end
		t = cyc;
	endtask

	task automatic t_reset_values();
		for (int u = 0; u < 3; u++) begin
			rd_chk("ctrl", PMT_CTRL_BASE + 5'(u), 8'h00);
			rd_chk("count", PMT_COUNT_BASE + 5'(u), 8'h00);
			rd_chk("period", PMT_PERIOD_BASE + 5'(u), 8'hff);
		end
		rd_chk("flags1", PMT_FLAGS1, 8'h00);
		rd_chk("flags3", PMT_FLAGS3, 8'h00);
		rd_chk("unmapped", 5'h1f, 8'h00);
	endtask
	task automatic t_reg_access();
		wr(PMT_CTRL_BASE, 8'hff);
		rd_chk("ctrl bit7", PMT_CTRL_BASE, 8'h7f);
		wr(PMT_CTRL_BASE, 8'h00);
		wr(PMT_COUNT_BASE + 5'h1, 8'h5a);
		wr(PMT_PERIOD_BASE + 5'h2, 8'ha5);
		rd_chk("count b", PMT_COUNT_BASE + 5'h1, 8'h5a);
		rd_chk("period c", PMT_PERIOD_BASE + 5'h2, 8'ha5);
	endtask
	// pulse spacing is (period+1) divided ticks, each 4^s instruction ticks of four ref cycles
	task automatic t_divider();
		int t1, t2;
		wr(PMT_PERIOD_BASE, 8'h02);
		for (int s = 0; s < 4; s++) begin
			wr(PMT_CTRL_BASE, 8'h04 | 8'(s));
			wait_match(0, t1);
			wait_match(0, t2);
			chk("match spacing", 16'(t2 - t1), 16'(3 * (1 << (2 * s)) * 4));
		end
		wr(PMT_CTRL_BASE, 8'h00);
		rd_chk("flags1", PMT_FLAGS1, 8'h02);
		wr(PMT_FLAG_CLEAR1, 8'h02);
		rd_chk("flags1 cleared", PMT_FLAGS1, 8'h00);
	endtask
	task automatic t_scaler_irq();
		int n;
		n = 0;
		wr(PMT_PERIOD_BASE + 5'h2, 8'h01);
		wr(PMT_ENABLES3, 8'h08);
		wr(PMT_CTRL_BASE + 5'h2, 8'h14);
		for (int i = 0; i < 300 && irq_q !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
			if (match_q[2] === 1'b1) n++;
		end
		wr(PMT_CTRL_BASE + 5'h2, 8'h00);
		chk("matches per flag", 16'(n), 16'h0003);
		rd_chk("flags3", PMT_FLAGS3, 8'h08);
		wr(PMT_ENABLES3, 8'h00);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("irq masked", {15'h0, irq_q}, 16'h0000);
		wr(PMT_FLAG_CLEAR3, 8'h08);
		wr(PMT_ENABLES3, 8'h08);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("irq cleared", {15'h0, irq_q}, 16'h0000);
		rd_chk("flags3 cleared", PMT_FLAGS3, 8'h00);
	endtask
	// unit b with its interrupt enabled; enable registers read back
	task automatic t_unit_b();
		int t1, t2;
		wr(PMT_ENABLES1, 8'h02);
		rd_chk("enables1", PMT_ENABLES1, 8'h02);
		wr(PMT_ENABLES1, 8'h00);
		wr(PMT_ENABLES3, 8'h02);
		rd_chk("enables3", PMT_ENABLES3, 8'h02);
		wr(PMT_PERIOD_BASE + 5'h1, 8'h03);
		wr(PMT_COUNT_BASE + 5'h1, 8'h00);
		wr(PMT_CTRL_BASE + 5'h1, 8'h04);
		wait_match(1, t1);
		wait_match(1, t2);
		wr(PMT_CTRL_BASE + 5'h1, 8'h00);
		chk("match spacing b", 16'(t2 - t1), 16'h0010);
		chk("irq b", {15'h0, irq_q}, 16'h0001);
		rd_chk("flags3 b", PMT_FLAGS3, 8'h02);
		wr(PMT_FLAG_CLEAR3, 8'h02);
		wr(PMT_ENABLES3, 8'h00);
		rd_chk("flags3 b cleared", PMT_FLAGS3, 8'h00);
	endtask
	// stopped timer keeps a written count, a control write leaves it
	task automatic t_stopped();
		int seen;
		seen = 0;
		wr(PMT_PERIOD_BASE, 8'h10);
		wr(PMT_COUNT_BASE, 8'h10);
		wr(PMT_CTRL_BASE, 8'h78);
		for (int i = 0; i < 100; i++) begin
			@(posedge ref_clk);
			#1;
			if (match_q[0] === 1'b1) seen++;
		end
		chk("stopped matches", 16'(seen), 16'h0000);
		rd_chk("count held", PMT_COUNT_BASE, 8'h10);
		wr(PMT_CTRL_BASE, 8'h00);
	endtask
	task automatic t_sleep();
		wr(PMT_PERIOD_BASE, 8'h40);
		wr(PMT_CTRL_BASE, 8'h04);
		@(posedge ref_clk);
		sleep <= 1'b1;
		wr(PMT_COUNT_BASE, 8'h20);
		repeat (50) @(posedge ref_clk);
		rd_chk("count asleep", PMT_COUNT_BASE, 8'h20);
		rd_chk("period asleep", PMT_PERIOD_BASE, 8'h40);
		@(posedge ref_clk);
		sleep <= 1'b0;
		wr(PMT_CTRL_BASE, 8'h00);
	endtask

	task automatic tally_and_finish();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#200us;
		failures++;
		tally_and_finish();
	end
	initial begin
		failures = 0;
		compares = 0;
		cyc = 0;
		resetn = 1'b0;
		sleep = 1'b0;
		bus = '0;
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		t_reset_values();
		t_reg_access();
		t_divider();
		t_scaler_irq();
		t_unit_b();
		t_stopped();
		t_sleep();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// file: verilog/pmt_divider.sv
// input divider: 1/4/16/64 on the instruction-clock enable
// assumes the enable is a one-cycle pulse on ref_clk
`timescale 1ns/10ps
`default_nettype none
module pmt_divider (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clear,
	input wire logic tick_in,
	input wire logic [1:0] select,
	output logic tick_out
);
	import pmt_pkg::*;
	logic [5:0] cnt_q;
	logic [5:0] last;
	always_comb begin
		unique case (select)
			2'h0: last = 6'h00;
			2'h1: last = 6'h03;
			2'h2: last = 6'h0f;
			2'h3: last = 6'h3f;
		endcase
	end
	assign tick_out = tick_in && (cnt_q >= last);
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 6'h00;
		end else if (clear) begin
			cnt_q <= 6'h00;
		end else if (tick_in) begin
			cnt_q <= (cnt_q >= last) ? 6'h00 : 6'(cnt_q + 6'h01);
		end
	end
endmodule
`default_nettype wire

// file: verilog/pmt_pkg.sv
// constants, register map and types for the three-unit period match timer
// assumes a single 200 MHz clock and a plain strobe register port
// How it works
// - sleep stops all three counters
// - sleep keeps count and period intact
// - bits 6-3 pick scaler 1:(n+1)
// - bit 2 runs or stops timer
// - bits 1-0 divide by 1/4/16/64
// - bit 7 reads zero, writes ignored
// - control bits read/write, reset zero
// - per unit 8-bit count and period
// - unit a flag/enable at bit 1
// - counts instruction clock through divider from 00h
// - match pulses, count clears, scaler advances
// - reset and control/count writes clear divider and scaler
// - scaler terminal count sets sticky flag
package pmt_pkg;
	localparam int unsigned PMT_UNITS = 3;
	localparam int unsigned PMT_ADDR_W = 5;
	// register indices
	localparam logic [4:0] PMT_CTRL_BASE = 5'h00;
	localparam logic [4:0] PMT_COUNT_BASE = 5'h04;
	localparam logic [4:0] PMT_PERIOD_BASE = 5'h08;
	localparam logic [4:0] PMT_FLAGS1 = 5'h0c;
	localparam logic [4:0] PMT_ENABLES1 = 5'h0d;
	localparam logic [4:0] PMT_FLAGS3 = 5'h0e;
	localparam logic [4:0] PMT_ENABLES3 = 5'h0f;
	localparam logic [4:0] PMT_FLAG_CLEAR1 = 5'h10;
	localparam logic [4:0] PMT_FLAG_CLEAR3 = 5'h11;
	// field positions
	localparam int unsigned PMT_BIT_UNIT_A = 1;
	localparam int unsigned PMT_BIT_UNIT_B = 1;
	localparam int unsigned PMT_BIT_UNIT_C = 3;
	localparam logic [6:0] PMT_CTRL_MASK = 7'h7f;
	localparam logic [7:0] PMT_COUNT_RESET = 8'h00;
	localparam logic [7:0] PMT_PERIOD_RESET = 8'hff;
	localparam logic [6:0] PMT_CTRL_RESET = 7'h00;
	// instruction clock is one quarter of the oscillator
	localparam int unsigned PMT_REF_MHZ = 200;
	localparam int unsigned PMT_INSTR_DIV = 4;
	localparam logic [1:0] PMT_INSTR_LAST = 2'(PMT_INSTR_DIV - 1);

	typedef struct packed {
		logic [3:0] output_scale_select;
		logic timer_run;
		logic [1:0] input_divide_select;
	} pmt_ctrl_s;

	typedef struct packed {
		logic [PMT_ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pmt_bus_s;
endpackage

// file: verilog/pmt_top.sv
// three period match timers behind a strobe register port
// assumes read data are sampled the cycle after the read strobe
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module pmt_top (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic sleep,
	input wire pmt_pkg::pmt_bus_s bus,
	output logic [7:0] rdata_q,
	output logic [pmt_pkg::PMT_UNITS-1:0] match_q,
	output logic irq_q
);
	import pmt_pkg::*;
	logic [1:0] pre_q;
	logic instr_tick;
	pmt_ctrl_s ctrl_q [PMT_UNITS];
	logic [7:0] count [PMT_UNITS];
	logic [7:0] period [PMT_UNITS];
	logic [PMT_UNITS-1:0] match;
	logic [PMT_UNITS-1:0] scaled;
	logic [PMT_UNITS-1:0] flag_q;
	logic [PMT_UNITS-1:0] enable_q;
	logic [PMT_UNITS-1:0] clr;
	logic [7:0] rd_d;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] base, input int unsigned i);
		hit = (a == 5'(base + 5'(i)));
	endfunction

	// sleep freezes the instruction-clock enable, so counters, dividers and scalers hold; register writes still land
	assign instr_tick = (pre_q == PMT_INSTR_LAST) && !sleep;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pre_q <= 2'h0;
		end else if (!sleep) begin
			pre_q <= 2'(pre_q + 2'h1);
		end
	end

	for (genvar i = 0; i < PMT_UNITS; i++) begin : g_unit
		always_ff @(posedge ref_clk or negedge resetn) begin
			if (!resetn) begin
				ctrl_q[i] <= PMT_CTRL_RESET;
			end else if (bus.wr && hit(bus.addr, PMT_CTRL_BASE, i)) begin
				ctrl_q[i] <= bus.wdata[6:0] & PMT_CTRL_MASK;
			end
		end
		pmt_unit #(.WIDTH(8)) u_unit (
			.ref_clk(ref_clk),
			.resetn(resetn),
			.tick(instr_tick),
			.ctrl(ctrl_q[i]),
			.ctrl_wr(bus.wr && hit(bus.addr, PMT_CTRL_BASE, i)),
			.count_wr(bus.wr && hit(bus.addr, PMT_COUNT_BASE, i)),
			.period_wr(bus.wr && hit(bus.addr, PMT_PERIOD_BASE, i)),
			.wdata(bus.wdata),
			.count_q(count[i]),
			.period_q(period[i]),
			.match(match[i]),
			.scaled(scaled[i])
		);
	end

	always_comb begin
		clr = '0;
		if (bus.wr && bus.addr == PMT_FLAG_CLEAR1) begin
			clr[0] = bus.wdata[PMT_BIT_UNIT_A];
		end
		if (bus.wr && bus.addr == PMT_FLAG_CLEAR3) begin
			clr[1] = bus.wdata[PMT_BIT_UNIT_B];
			clr[2] = bus.wdata[PMT_BIT_UNIT_C];
		end
	end
	// a scaler event in the same cycle as a clear wins
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			flag_q <= '0;
		end else begin
			flag_q <= (flag_q & ~clr) | scaled;
		end
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			enable_q <= '0;
		end else if (bus.wr && bus.addr == PMT_ENABLES1) begin
			enable_q[0] <= bus.wdata[PMT_BIT_UNIT_A];
		end else if (bus.wr && bus.addr == PMT_ENABLES3) begin
			enable_q[1] <= bus.wdata[PMT_BIT_UNIT_B];
			enable_q[2] <= bus.wdata[PMT_BIT_UNIT_C];
		end
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			irq_q <= 1'b0;
			match_q <= '0;
		end else begin
			irq_q <= |(((flag_q & ~clr) | scaled) & enable_q);
			match_q <= match;
		end
	end

	always_comb begin
		rd_d = 8'h00;
		for (int i = 0; i < PMT_UNITS; i++) begin
			if (hit(bus.addr, PMT_CTRL_BASE, i)) begin
				rd_d = {1'b0, ctrl_q[i]};
			end
			if (hit(bus.addr, PMT_COUNT_BASE, i)) begin
				rd_d = count[i];
			end
			if (hit(bus.addr, PMT_PERIOD_BASE, i)) begin
				rd_d = period[i];
			end
		end
		unique case (bus.addr)
			PMT_FLAGS1: rd_d[PMT_BIT_UNIT_A] = flag_q[0];
			PMT_ENABLES1: rd_d[PMT_BIT_UNIT_A] = enable_q[0];
			PMT_FLAGS3: begin
				rd_d[PMT_BIT_UNIT_B] = flag_q[1];
				rd_d[PMT_BIT_UNIT_C] = flag_q[2];
			end
			PMT_ENABLES3: begin
				rd_d[PMT_BIT_UNIT_B] = enable_q[1];
				rd_d[PMT_BIT_UNIT_C] = enable_q[2];
			end
			default: ;
		endcase
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 8'h00;
		end else if (bus.rd) begin
			rdata_q <= rd_d;
		end else begin
			rdata_q <= 8'h00;
		end
	end

	a_sleep_freeze: assert property (@(posedge ref_clk) disable iff (!resetn)
		sleep && !bus.wr |=> count[0] == $past(count[0]) && period[0] == $past(period[0]))
		else $error("unit a changed in sleep");
	a_flag_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
		scaled[0] |=> flag_q[0]) else $error("flag a not set");
	a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
		flag_q[1] && !clr[1] |=> flag_q[1]) else $error("flag b lost");
	a_ctrl_bit7: assert property (@(posedge ref_clk) disable iff (!resetn)
		bus.rd && bus.addr == PMT_CTRL_BASE |=> rdata_q[7] == 1'b0) else $error("bit 7 read one");
	a_irq_level: assert property (@(posedge ref_clk) disable iff (!resetn)
		flag_q[2] && enable_q[2] && !clr[2] |=> irq_q) else $error("irq missing");
	a_match_out: assert property (@(posedge ref_clk) disable iff (!resetn)
		match[1] |=> match_q[1]) else $error("match out missing");
	a_period_rst: assert property (@(posedge ref_clk) $rose(resetn) |-> period[2] == PMT_PERIOD_RESET)
		else $error("period not ff");
	a_run_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
		!ctrl_q[0].timer_run |-> !match[0]) else $error("match while stopped");
	c_irq: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(irq_q));
	c_scale16: cover property (@(posedge ref_clk) disable iff (!resetn)
		scaled[0] && ctrl_q[0].output_scale_select == 4'hf);
	c_sleep_match: cover property (@(posedge ref_clk) disable iff (!resetn) $fell(sleep) ##[1:50] match[0]);
endmodule
`default_nettype wire

// file: verilog/pmt_unit.sv
// one 8-bit period match unit with divider and output scaler
// assumes tick is the instruction-clock enable already gated by sleep
`timescale 1ns/10ps
`default_nettype none
module pmt_unit #(
	parameter int unsigned WIDTH = 8
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic tick,
	input wire pmt_pkg::pmt_ctrl_s ctrl,
	input wire logic ctrl_wr,
	input wire logic count_wr,
	input wire logic period_wr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] count_q,
	output logic [WIDTH-1:0] period_q,
	output logic match,
	output logic scaled
);
	import pmt_pkg::*;
	logic div_tick;
	logic [3:0] scale_q;
	logic run_tick;
	assign run_tick = tick && ctrl.timer_run;
	pmt_divider u_div (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clear(ctrl_wr || count_wr),
		.tick_in(run_tick),
		.select(ctrl.input_divide_select),
		.tick_out(div_tick)
	);
	// equality clears at this tick, so one period is period+1 ticks
	assign match = div_tick && (count_q == period_q);
	assign scaled = match && (scale_q >= ctrl.output_scale_select);
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			count_q <= WIDTH'(PMT_COUNT_RESET);
		end else if (count_wr) begin
			count_q <= wdata;
		end else if (div_tick) begin
			count_q <= match ? WIDTH'(PMT_COUNT_RESET) : WIDTH'(count_q + 1'b1);
		end
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			period_q <= WIDTH'(PMT_PERIOD_RESET);
		end else if (period_wr) begin
			period_q <= wdata;
		end
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			scale_q <= 4'h0;
		end else if (ctrl_wr || count_wr) begin
			scale_q <= 4'h0;
		end else if (match) begin
			scale_q <= scaled ? 4'h0 : 4'(scale_q + 4'h1);
		end
	end
	a_stop_holds: assert property (@(posedge ref_clk) disable iff (!resetn)
		!ctrl.timer_run && !count_wr |=> count_q == $past(count_q)) else $error("count moved while stopped");
	a_match_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
		match && !count_wr |=> count_q == WIDTH'(PMT_COUNT_RESET)) else $error("count not cleared after match");
endmodule
`default_nettype wire
